/* File: hdl/lcd_bias_rail_sequencer.sv */
// five-rail display bias power-up and shutdown sequencer
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_rail_sequencer #(
  parameter int unsigned TIMEOUT_CYC = lcd_bias_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_primary_enable,
  input  wire logic       i_secondary_enable,
  input  wire logic       i_supply_ok,
  input  wire logic       i_logic_good,
  input  wire logic       i_analog_good,
  input  wire logic       i_neg_good,
  input  wire logic       i_pos_good,
  input  wire logic       i_common_good,
  input  wire logic       i_pos_low,
  input  wire logic       i_neg_low,
  input  wire logic       i_analog_low,
  input  wire logic       i_common_low,
  input  wire logic       i_setpoint_ok,
  input  wire logic       i_headroom_low,
  input  wire logic       i_boost_sw,
  input  wire logic       i_ext_sync,
  input  wire logic       i_sync_sel,
  output logic            o_sleep,
  output logic            o_logic_rail_en,
  output logic            o_analog_rail_en,
  output logic            o_neg_gate_en,
  output logic            o_pos_gate_en,
  output logic            o_common_en,
  output logic            o_analog_pd,
  output logic            o_neg_gate_pd,
  output logic            o_pos_gate_pd,
  output logic            o_common_pd,
  output logic            o_boost_raise,
  output logic            o_pump_clk,
  output logic            o_softstart_fault,
  output logic            o_setpoint_fault,
  output logic [2:0]      o_bypass
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYC - 1);

  rail_flags_if flags ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // two flops per comparator flag
  rail_flag_sync #(
    .WIDTH (lcd_bias_pkg::FLAG_COUNT)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_raw      ({i_sync_sel, i_ext_sync, i_boost_sw, i_headroom_low, i_setpoint_ok,
                  i_common_low, i_analog_low, i_neg_low, i_pos_low, i_common_good,
                  i_pos_good, i_neg_good, i_analog_good, i_logic_good, i_supply_ok,
                  i_secondary_enable, i_primary_enable}),
    .flags      (flags)
  );

  lcd_bias_pkg::state_type state_ff;
  lcd_bias_pkg::state_type nxt_state;
  logic [TW-1:0]           timer_ff;
  logic [TW-1:0]           nxt_timer;
  logic [3:0]              want_ff;     // analog, neg, pos, common requested
  logic [3:0]              nxt_want;
  logic [2:0]              bypass_ff;
  logic [2:0]              nxt_bypass;
  logic                    ss_fault_ff;
  logic                    sp_fault_ff;
  logic                    nxt_ss_fault;
  logic                    nxt_sp_fault;

  ////////////////////////////////////////////////////////////////////////////
  // decoded conditions
  wire timed_out    = (timer_ff == TIMEOUT_LAST);
  wire state_change = (nxt_state != state_ff);
  wire all_decayed  = flags.pos_low & flags.analog_low & flags.common_low;
  wire stage_active = (state_ff != lcd_bias_pkg::ST_SLEEP) &&
                      (state_ff != lcd_bias_pkg::ST_OFF) &&
                      (state_ff != lcd_bias_pkg::ST_FAULT);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_state    = state_ff;
    nxt_bypass   = bypass_ff;
    nxt_ss_fault = ss_fault_ff;
    nxt_sp_fault = sp_fault_ff;
    case (state_ff)
      lcd_bias_pkg::ST_SLEEP: begin
        // leave sleep only once supply is above lockout
        if (flags.supply_ok) begin
          nxt_state = lcd_bias_pkg::ST_OFF;
        end
      end
      lcd_bias_pkg::ST_OFF: begin
        // primary enable alone starts the logic rail
        if (flags.primary_enable) begin
          nxt_state  = lcd_bias_pkg::ST_LOGIC_UP;
          nxt_bypass = 3'h0;
        end
      end
      lcd_bias_pkg::ST_LOGIC_UP: begin
        // secondary honoured only after logic rail good
        if (!flags.primary_enable) begin
          nxt_state = lcd_bias_pkg::ST_OFF;
        end else if (flags.logic_good && flags.secondary_enable) begin
          nxt_state = lcd_bias_pkg::ST_ANALOG_UP;
        end else if (!flags.logic_good && timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_ss_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_ANALOG_UP: begin
        if (flags.analog_good) begin
          nxt_state = lcd_bias_pkg::ST_NEG_UP;
        end else if (timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_ss_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_NEG_UP: begin
        // positive gate waits for negative gate magnitude good
        if (flags.neg_good) begin
          nxt_state = lcd_bias_pkg::ST_POS_UP;
        end else if (timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_ss_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_POS_UP: begin
        if (flags.pos_good) begin
          nxt_state = lcd_bias_pkg::ST_COMMON_WAIT;
        end else if (timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_ss_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_COMMON_WAIT: begin
        // common rail needs a valid setpoint within the window
        if (flags.setpoint_ok) begin
          nxt_state = lcd_bias_pkg::ST_COMMON_UP;
        end else if (timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_sp_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_COMMON_UP: begin
        if (flags.common_good) begin
          nxt_state = lcd_bias_pkg::ST_ON;
        end else if (timed_out) begin
          nxt_state    = lcd_bias_pkg::ST_FAULT;
          nxt_ss_fault = 1'b1;
        end
      end
      lcd_bias_pkg::ST_ON: begin
        // primary low is ignored while secondary stays high
        if (!flags.secondary_enable) begin
          nxt_state = lcd_bias_pkg::ST_DECAY;
        end
      end
      lcd_bias_pkg::ST_DECAY: begin
        // wait for decay, bypass stragglers at time-out
        if (all_decayed) begin
          nxt_state = lcd_bias_pkg::ST_NEG_DOWN;
        end else if (timed_out) begin
          nxt_state                          = lcd_bias_pkg::ST_NEG_DOWN;
          nxt_bypass[lcd_bias_pkg::BYP_ANALOG] = ~flags.analog_low;
          nxt_bypass[lcd_bias_pkg::BYP_COMMON] = ~flags.common_low;
          nxt_bypass[lcd_bias_pkg::BYP_POS]    = ~flags.pos_low;
        end
      end
      lcd_bias_pkg::ST_NEG_DOWN: begin
        // primary low honoured after 30 percent or time-out
        if (flags.neg_low || timed_out) begin
          nxt_state = lcd_bias_pkg::ST_LOGIC_HOLD;
        end
      end
      lcd_bias_pkg::ST_LOGIC_HOLD: begin
        if (!flags.primary_enable) begin
          nxt_state = lcd_bias_pkg::ST_OFF;
        end
      end
      lcd_bias_pkg::ST_FAULT: begin
        // fault latches until the host drops primary enable
        if (!flags.primary_enable) begin
          nxt_state    = lcd_bias_pkg::ST_OFF;
          nxt_ss_fault = 1'b0;
          nxt_sp_fault = 1'b0;
        end
      end
      default: begin
        nxt_state = lcd_bias_pkg::ST_SLEEP;
      end
    endcase
    if (!flags.supply_ok) begin
      nxt_state = lcd_bias_pkg::ST_SLEEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail requests per state; analog needs both enables to start
  // analog rail requested only from analog ramp to on
  always_comb begin
    nxt_want = 4'h0;
    case (nxt_state)
      lcd_bias_pkg::ST_ANALOG_UP:   nxt_want = 4'h1;
      lcd_bias_pkg::ST_NEG_UP:      nxt_want = 4'h3;
      lcd_bias_pkg::ST_POS_UP:      nxt_want = 4'h7;
      lcd_bias_pkg::ST_COMMON_WAIT: nxt_want = 4'h7;
      lcd_bias_pkg::ST_COMMON_UP:   nxt_want = 4'hF;
      lcd_bias_pkg::ST_ON:          nxt_want = 4'hF;
      lcd_bias_pkg::ST_DECAY:       nxt_want = 4'h2;
      default:                      nxt_want = 4'h0;
    endcase
  end

  // shared time-out counter restarts on every state change
  assign nxt_timer = (state_change || timed_out) ? '0 : timer_ff + TW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // state, timer and flags
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_ff    <= lcd_bias_pkg::ST_SLEEP;
      timer_ff    <= '0;
      want_ff     <= 4'h0;
      bypass_ff   <= 3'h0;
      ss_fault_ff <= 1'b0;
      sp_fault_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      timer_ff    <= nxt_timer;
      want_ff     <= nxt_want;
      bypass_ff   <= nxt_bypass;
      ss_fault_ff <= nxt_ss_fault;
      sp_fault_ff <= nxt_sp_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull-downs drop one edge ahead of the matching enable
  // pull-down while active and not requested; enable waits for release
  // outside active states every pull-down is released
  wire [3:0] nxt_pd = stage_active ? ~want_ff : 4'h0;
  wire [3:0] nxt_en = want_ff & ~{o_common_pd, o_pos_gate_pd, o_neg_gate_pd, o_analog_pd};

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_analog_pd      <= 1'b0;
      o_neg_gate_pd    <= 1'b0;
      o_pos_gate_pd    <= 1'b0;
      o_common_pd      <= 1'b0;
      o_analog_rail_en <= 1'b0;
      o_neg_gate_en    <= 1'b0;
      o_pos_gate_en    <= 1'b0;
      o_common_en      <= 1'b0;
    end else begin
      o_analog_pd      <= nxt_pd[0];
      o_neg_gate_pd    <= nxt_pd[1];
      o_pos_gate_pd    <= nxt_pd[2];
      o_common_pd      <= nxt_pd[3];
      o_analog_rail_en <= nxt_en[0];
      o_neg_gate_en    <= nxt_en[1];
      o_pos_gate_en    <= nxt_en[2];
      o_common_en      <= nxt_en[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs and logic rail
  // logic rail follows the active states
  // headroom request only while analog regulator runs
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sleep           <= 1'b1;
      o_logic_rail_en   <= 1'b0;
      o_boost_raise     <= 1'b0;
      o_softstart_fault <= 1'b0;
      o_setpoint_fault  <= 1'b0;
      o_bypass          <= 3'h0;
    end else begin
      o_sleep           <= (state_ff == lcd_bias_pkg::ST_SLEEP);
      o_logic_rail_en   <= stage_active;
      o_boost_raise     <= o_analog_rail_en & flags.headroom_low;
      o_softstart_fault <= ss_fault_ff;
      o_setpoint_fault  <= sp_fault_ff;
      o_bypass          <= bypass_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge pump clock: boost phase, or external sync regenerated
  // limitation: regenerated period resolves to whole core cycles
  logic [lcd_bias_pkg::PUMP_CNT_W-1:0] per_cnt_ff;
  logic [lcd_bias_pkg::PUMP_CNT_W-1:0] half_ff;
  logic [lcd_bias_pkg::PUMP_CNT_W-1:0] gen_cnt_ff;
  logic                                sync_d_ff;
  logic                                regen_ff;

  wire sync_rise = flags.ext_sync & ~sync_d_ff;
  wire gen_flip  = (gen_cnt_ff >= half_ff);

  // period measured on each sync rise, toggle every half period
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      per_cnt_ff <= '0;
      half_ff    <= '0;
      gen_cnt_ff <= '0;
      sync_d_ff  <= 1'b0;
      regen_ff   <= 1'b0;
      o_pump_clk <= 1'b0;
    end else begin
      sync_d_ff  <= flags.ext_sync;
      per_cnt_ff <= sync_rise ? '0 : per_cnt_ff + 1'b1;
      if (sync_rise) begin
        half_ff <= (per_cnt_ff + 1'b1) >> 1;
      end
      gen_cnt_ff <= gen_flip ? lcd_bias_pkg::PUMP_CNT_W'(1) : gen_cnt_ff + 1'b1;
      if (gen_flip) begin
        regen_ff <= ~regen_ff;
      end
      o_pump_clk <= flags.sync_sel ? regen_ff : flags.boost_sw;
    end
  end

endmodule : lcd_bias_rail_sequencer
`default_nettype wire

/* File: hdl/lcd_bias_pkg.sv */
// constants and types shared by the bias rail sequencer
package lcd_bias_pkg;

  // core clock rate and time-out figures
  localparam int unsigned CORE_CLK_HZ       = 25_000_000;
  localparam int unsigned TIMEOUT_MS        = 50;
  localparam int unsigned TIMEOUT_CYCLES    = TIMEOUT_MS * (CORE_CLK_HZ / 1000);

  // number of pin inputs that pass the synchroniser
  localparam int unsigned FLAG_COUNT        = 17;

  // bit positions of the pin inputs in the raw flag vector
  localparam int unsigned POS_PRIMARY_EN    = 0;
  localparam int unsigned POS_SECONDARY_EN  = 1;
  localparam int unsigned POS_SUPPLY_OK     = 2;
  localparam int unsigned POS_LOGIC_GOOD    = 3;
  localparam int unsigned POS_ANALOG_GOOD   = 4;
  localparam int unsigned POS_NEG_GOOD      = 5;
  localparam int unsigned POS_POS_GOOD      = 6;
  localparam int unsigned POS_COMMON_GOOD   = 7;
  localparam int unsigned POS_POS_LOW       = 8;
  localparam int unsigned POS_NEG_LOW       = 9;
  localparam int unsigned POS_ANALOG_LOW    = 10;
  localparam int unsigned POS_COMMON_LOW    = 11;
  localparam int unsigned POS_SETPOINT_OK   = 12;
  localparam int unsigned POS_HEADROOM_LOW  = 13;
  localparam int unsigned POS_BOOST_SW      = 14;
  localparam int unsigned POS_EXT_SYNC      = 15;
  localparam int unsigned POS_SYNC_SEL      = 16;

  // pump clock regenerator period counter width
  localparam int unsigned PUMP_CNT_W        = 8;

  // bypass flag positions
  localparam int unsigned BYP_ANALOG        = 0;
  localparam int unsigned BYP_COMMON        = 1;
  localparam int unsigned BYP_POS           = 2;

  // sequencer states
  typedef enum logic [3:0] {
    ST_SLEEP,
    ST_OFF,
    ST_LOGIC_UP,
    ST_ANALOG_UP,
    ST_NEG_UP,
    ST_POS_UP,
    ST_COMMON_WAIT,
    ST_COMMON_UP,
    ST_ON,
    ST_DECAY,
    ST_NEG_DOWN,
    ST_LOGIC_HOLD,
    ST_FAULT
  } state_type;

endpackage : lcd_bias_pkg

/* File: hdl/rail_flags_if.sv */
// synchronised pin flags passed from the synchroniser to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface rail_flags_if;
  logic primary_enable;
  logic secondary_enable;
  logic supply_ok;
  logic logic_good;
  logic analog_good;
  logic neg_good;
  logic pos_good;
  logic common_good;
  logic pos_low;
  logic neg_low;
  logic analog_low;
  logic common_low;
  logic setpoint_ok;
  logic headroom_low;
  logic boost_sw;
  logic ext_sync;
  logic sync_sel;

  modport src (
    output primary_enable, secondary_enable, supply_ok, logic_good, analog_good,
    output neg_good, pos_good, common_good, pos_low, neg_low, analog_low,
    output common_low, setpoint_ok, headroom_low, boost_sw, ext_sync, sync_sel
  );
  modport dst (
    input  primary_enable, secondary_enable, supply_ok, logic_good, analog_good,
    input  neg_good, pos_good, common_good, pos_low, neg_low, analog_low,
    input  common_low, setpoint_ok, headroom_low, boost_sw, ext_sync, sync_sel
  );
endinterface : rail_flags_if
`default_nettype wire

/* File: hdl/rail_flag_sync.sv */
// two-flop synchroniser bank for the sequencer's pin inputs
`timescale 1ns/1ps
`default_nettype none
module rail_flag_sync #(
  parameter int unsigned WIDTH = lcd_bias_pkg::FLAG_COUNT
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_raw,
  rail_flags_if.src             flags
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // one pair of flops per pin; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_sync
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= i_raw[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // name the synchronised bits
  assign flags.primary_enable   = sync_ff[lcd_bias_pkg::POS_PRIMARY_EN];
  assign flags.secondary_enable = sync_ff[lcd_bias_pkg::POS_SECONDARY_EN];
  assign flags.supply_ok        = sync_ff[lcd_bias_pkg::POS_SUPPLY_OK];
  assign flags.logic_good       = sync_ff[lcd_bias_pkg::POS_LOGIC_GOOD];
  assign flags.analog_good      = sync_ff[lcd_bias_pkg::POS_ANALOG_GOOD];
  assign flags.neg_good         = sync_ff[lcd_bias_pkg::POS_NEG_GOOD];
  assign flags.pos_good         = sync_ff[lcd_bias_pkg::POS_POS_GOOD];
  assign flags.common_good      = sync_ff[lcd_bias_pkg::POS_COMMON_GOOD];
  assign flags.pos_low          = sync_ff[lcd_bias_pkg::POS_POS_LOW];
  assign flags.neg_low          = sync_ff[lcd_bias_pkg::POS_NEG_LOW];
  assign flags.analog_low       = sync_ff[lcd_bias_pkg::POS_ANALOG_LOW];
  assign flags.common_low       = sync_ff[lcd_bias_pkg::POS_COMMON_LOW];
  assign flags.setpoint_ok      = sync_ff[lcd_bias_pkg::POS_SETPOINT_OK];
  assign flags.headroom_low     = sync_ff[lcd_bias_pkg::POS_HEADROOM_LOW];
  assign flags.boost_sw         = sync_ff[lcd_bias_pkg::POS_BOOST_SW];
  assign flags.ext_sync         = sync_ff[lcd_bias_pkg::POS_EXT_SYNC];
  assign flags.sync_sel         = sync_ff[lcd_bias_pkg::POS_SYNC_SEL];

endmodule : rail_flag_sync
`default_nettype wire

/* File: dv/rail_model.sv */
// behavioural rails and threshold comparators beyond the sequencer
`timescale 1ns/1ps
`default_nettype none
module rail_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_stuck,
  input  wire logic [4:0] i_en,
  output var  logic [4:0] o_good,
  output var  logic [4:0] o_low
);
  logic [2:0] lvl_ff [5];
  // one step a cycle up or down; stuck keeps the positive gate charged
  always_ff @(posedge i_core_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (i_reset) lvl_ff[k] <= 3'h0;
      else if (i_en[k] && lvl_ff[k] != 3'h7) lvl_ff[k] <= lvl_ff[k] + 3'h1;
      else if (!i_en[k] && lvl_ff[k] != 3'h0 && !(i_stuck && k == 3))
        lvl_ff[k] <= lvl_ff[k] - 3'h1;
    end
  end
  // good only at the top step, low only when fully decayed
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      o_good[k] = (lvl_ff[k] == 3'h7);
      o_low[k]  = (lvl_ff[k] == 3'h0);
    end
  end
endmodule : rail_model
`default_nettype wire

/* File: dv/lcd_bias_props.sv */
// port assertions for the bias rail sequencer
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_props (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_secondary_enable,
  input wire logic       i_primary_enable,
  input wire logic       i_supply_ok,
  input wire logic       i_logic_good,
  input wire logic       i_neg_good,
  input wire logic       i_pos_good,
  input wire logic       i_pos_low,
  input wire logic       i_setpoint_ok,
  input wire logic       i_headroom_low,
  input wire logic       i_boost_sw,
  input wire logic       i_sync_sel,
  input wire logic       o_sleep,
  input wire logic       o_logic_rail_en,
  input wire logic       o_analog_rail_en,
  input wire logic       o_neg_gate_en,
  input wire logic       o_pos_gate_en,
  input wire logic       o_common_en,
  input wire logic       o_analog_pd,
  input wire logic       o_neg_gate_pd,
  input wire logic       o_pos_gate_pd,
  input wire logic       o_common_pd,
  input wire logic       o_boost_raise,
  input wire logic       o_pump_clk,
  input wire logic       o_softstart_fault,
  input wire logic       o_setpoint_fault,
  input wire logic [2:0] o_bypass
);
  logic [2:0] up_ff;
  // cycles since reset, so the boost and pump checks never look into reset
  always_ff @(posedge i_core_clk) begin
    if (i_reset) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_sleep; (!i_supply_ok) [*6] |-> o_sleep && !o_logic_rail_en; endproperty
  a_sleep: assert property (p_sleep) else $error("lockout not kept");
  property p_ana; $rose(o_analog_rail_en) |->
    $past(i_secondary_enable, 3) && $past(i_logic_good, 3) && o_logic_rail_en; endproperty
  a_ana: assert property (p_ana) else $error("analog rail early");
  property p_pos; $rose(o_pos_gate_en) |-> o_neg_gate_en && $past(i_neg_good, 3); endproperty
  a_pos: assert property (p_pos) else $error("positive gate early");
  property p_com; $rose(o_common_en) |-> $past(i_pos_good, 3) && $past(i_setpoint_ok, 3)
    && $past(o_common_pd, 2) && !$past(o_common_pd); endproperty
  a_com: assert property (p_com) else $error("common rail order");
  property p_logic; (i_primary_enable && i_supply_ok) [*8] |->
    o_logic_rail_en || o_softstart_fault || o_setpoint_fault; endproperty
  a_logic: assert property (p_logic) else $error("logic rail missing");
  property p_aoff; (!i_secondary_enable) [*8] |-> !o_analog_rail_en; endproperty
  a_aoff: assert property (p_aoff) else $error("analog rail alone");
  property p_neg; $fell(o_neg_gate_en) && !o_sleep |=> o_bypass[2] || o_sleep
    || o_softstart_fault || o_setpoint_fault || $past(i_pos_low, 4); endproperty
  a_neg: assert property (p_neg) else $error("negative gate off early");
  property p_rel; !o_logic_rail_en |->
    !(o_analog_pd || o_neg_gate_pd || o_pos_gate_pd || o_common_pd); endproperty
  a_rel: assert property (p_rel) else $error("pull-down left on");
  property p_boost; up_ff == 3'h7 && o_analog_rail_en && $past(o_analog_rail_en)
    && $past(i_headroom_low, 2) && $past(i_headroom_low, 3) |-> o_boost_raise; endproperty
  a_boost: assert property (p_boost) else $error("boost raise missing");
  property p_pump; up_ff == 3'h7 && !$past(i_sync_sel, 3) |->
    o_pump_clk == $past(i_boost_sw, 2) || o_pump_clk == $past(i_boost_sw, 3); endproperty
  a_pump: assert property (p_pump) else $error("pump clock wrong");
  c_com: cover property ($rose(o_common_en));
  c_byp: cover property ($rose(o_bypass[2]));
  c_flt: cover property ($rose(o_setpoint_fault));
endmodule : lcd_bias_props
bind lcd_bias_rail_sequencer lcd_bias_props u_props (.i_core_clk, .i_reset,
  .i_secondary_enable, .i_primary_enable, .i_supply_ok, .i_logic_good, .i_neg_good,
  .i_pos_good, .i_pos_low, .i_setpoint_ok, .i_headroom_low, .i_boost_sw, .i_sync_sel,
  .o_sleep, .o_logic_rail_en, .o_analog_rail_en, .o_neg_gate_en, .o_pos_gate_en,
  .o_common_en, .o_analog_pd, .o_neg_gate_pd, .o_pos_gate_pd, .o_common_pd,
  .o_boost_raise, .o_pump_clk, .o_softstart_fault, .o_setpoint_fault, .o_bypass);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the bias rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned TO = 50;
  logic i_core_clk = 1'b0, i_reset = 1'b1, i_primary_enable = 1'b0, unused_low;
  logic i_secondary_enable = 1'b0, i_supply_ok = 1'b0, i_setpoint_ok = 1'b0;
  logic i_headroom_low = 1'b0, i_boost_sw = 1'b0, i_ext_sync = 1'b0, i_sync_sel = 1'b0;
  logic stuck = 1'b0, i_logic_good, i_analog_good, i_neg_good, i_pos_good, i_common_good;
  logic i_pos_low, i_neg_low, i_analog_low, i_common_low, o_sleep, o_logic_rail_en;
  logic o_analog_rail_en, o_neg_gate_en, o_pos_gate_en, o_common_en, o_analog_pd;
  logic o_neg_gate_pd, o_pos_gate_pd, o_common_pd, o_boost_raise, o_pump_clk;
  logic o_softstart_fault, o_setpoint_fault;
  logic [2:0] o_bypass;
  logic [4:0] en_seen = 5'h00;
  logic [31:0] lfsr = 32'h088C5295;
  int n_errors = 0, compares = 0, next_rail = 0, ones = 0;
  wire [4:0] en = {o_common_en, o_pos_gate_en, o_neg_gate_en, o_analog_rail_en, o_logic_rail_en};
  always #20 i_core_clk = ~i_core_clk;
  lcd_bias_rail_sequencer #(.TIMEOUT_CYC(TO)) dut (.i_core_clk, .i_reset, .i_primary_enable,
    .i_secondary_enable, .i_supply_ok, .i_logic_good, .i_analog_good, .i_neg_good,
    .i_pos_good, .i_common_good, .i_pos_low, .i_neg_low, .i_analog_low, .i_common_low,
    .i_setpoint_ok, .i_headroom_low, .i_boost_sw, .i_ext_sync, .i_sync_sel, .o_sleep,
    .o_logic_rail_en, .o_analog_rail_en, .o_neg_gate_en, .o_pos_gate_en, .o_common_en,
    .o_analog_pd, .o_neg_gate_pd, .o_pos_gate_pd, .o_common_pd, .o_boost_raise,
    .o_pump_clk, .o_softstart_fault, .o_setpoint_fault, .o_bypass);
  rail_model rails (.i_core_clk, .i_reset, .i_stuck(stuck), .i_en(en),
    .o_good({i_common_good, i_pos_good, i_neg_good, i_analog_good, i_logic_good}),
    .o_low({i_common_low, i_pos_low, i_neg_low, i_analog_low, unused_low}));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : idle
  // random headroom and boost phase, new each falling edge
  always @(negedge i_core_clk) begin
    lfsr <= lfsr_next(lfsr);
    i_headroom_low <= lfsr[3];
    i_boost_sw <= lfsr[7];
  end
  // order model: rails come up strictly in turn, restart when logic drops
  always @(negedge i_core_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (en[k] === 1'b1 && en_seen[k] !== 1'b1) begin
        chk(8'(k), 8'(next_rail));
        next_rail = k + 1;
      end
    end
    if (o_logic_rail_en !== 1'b1) next_rail = 0;
    en_seen <= en;
  end
  // hang guard, far beyond the expected run
  initial begin
    #(40 * 5000);
    n_errors++;
    print_verdict();
  end
  initial begin
    idle(8);
    i_reset <= 1'b0;
    chk({o_sleep, o_logic_rail_en, o_bypass, o_neg_gate_pd}, 8'h20);
    // both enables while locked out
    i_primary_enable <= 1'b1;
    i_secondary_enable <= 1'b1;
    idle(20);
    chk({o_sleep, o_logic_rail_en}, 8'h02);
    // secondary alone once the lockout clears
    i_primary_enable <= 1'b0;
    i_supply_ok <= 1'b1;
    idle(20);
    chk({o_sleep, o_logic_rail_en, o_analog_rail_en}, 8'h00);
    i_primary_enable <= 1'b1;
    for (int i = 0; i < 20 && o_logic_rail_en !== 1'b1; i++) idle(1);
    chk({o_analog_pd, o_neg_gate_pd, o_pos_gate_pd, o_common_pd}, 8'h0F);
    chk(o_logic_rail_en, 1'b1);
    for (int i = 0; i < 100 && o_pos_gate_en !== 1'b1; i++) idle(1);
    idle(30);
    chk({o_common_en, o_common_pd, o_setpoint_fault}, 8'h02);
    i_setpoint_ok <= 1'b1;
    for (int i = 0; i < 30 && o_common_en !== 1'b1; i++) idle(1);
    chk({o_common_en, o_setpoint_fault}, 8'h02);
    // primary dropped first is held off while secondary stays high
    stuck <= 1'b1;
    i_primary_enable <= 1'b0;
    idle(10);
    chk({o_logic_rail_en, o_analog_rail_en, o_common_en}, 8'h07);
    i_secondary_enable <= 1'b0;
    idle(TO - 10);
    chk({o_neg_gate_en, o_logic_rail_en, o_bypass}, 8'h18);
    idle(40);
    chk(o_bypass, 3'h4);
    chk({o_logic_rail_en, o_neg_gate_en, o_neg_gate_pd, o_pos_gate_pd}, 8'h00);
    // regular start with no setpoint ever arriving
    stuck <= 1'b0;
    i_setpoint_ok <= 1'b0;
    i_primary_enable <= 1'b1;
    idle(5);
    i_secondary_enable <= 1'b1;
    for (int i = 0; i < 300 && o_setpoint_fault !== 1'b1; i++) idle(1);
    chk({o_setpoint_fault, o_common_en, o_logic_rail_en, o_bypass}, 8'h20);
    i_secondary_enable <= 1'b0;
    idle(3);
    i_primary_enable <= 1'b0;
    idle(10);
    chk(o_setpoint_fault, 1'b0);
    i_supply_ok <= 1'b0;
    idle(10);
    chk(o_sleep, 1'b1);
    // external sync of 8 cycles: regenerated pump clock must sit high half the time
    i_sync_sel <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      i_ext_sync <= i[2];
      if (i >= 32) ones += o_pump_clk;
      idle(1);
    end
    chk(8'(ones), 8'h10);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
